// ===== pkg/qei_pkg.sv
// constants shared by the quadrature encoder interface
package qei_pkg;
	// register byte offsets
	localparam logic [7:0] QEI_OFS_CTRL = 8'h00;
	localparam logic [7:0] QEI_OFS_INC = 8'h04;
	localparam logic [7:0] QEI_OFS_POS = 8'h08;
	localparam logic [7:0] QEI_OFS_FRAC = 8'h0C;
	localparam logic [7:0] QEI_OFS_IDX_CAP = 8'h10;
	localparam logic [7:0] QEI_OFS_SW_CAP = 8'h14;
	localparam logic [7:0] QEI_OFS_WARN = 8'h18;
	localparam logic [7:0] QEI_OFS_STAT = 8'h1C;
	localparam logic [7:0] QEI_OFS_MASK = 8'h20;
	// control field positions
	localparam int QEI_CTRL_DEC = 0;
	localparam int QEI_CTRL_POL_A = 1;
	localparam int QEI_CTRL_POL_B = 2;
	localparam int QEI_CTRL_POL_N = 3;
	localparam int QEI_CTRL_CLR_N = 4;
	localparam int QEI_CTRL_CLR_ONCE = 5;
	localparam int QEI_CTRL_W = 6;
	// status / mask field positions
	localparam int QEI_ST_A = 0;
	localparam int QEI_ST_B = 1;
	localparam int QEI_ST_N = 2;
	localparam int QEI_ST_WARN = 3;
	localparam int QEI_ST_SW = 4;
	localparam int QEI_ST_QERR = 5;
	localparam int QEI_ST_DONE = 6;
	localparam int QEI_ST_W = 7;
	// reset values
	localparam logic [QEI_CTRL_W-1:0] QEI_CTRL_RST = 6'h00;
	localparam logic [31:0] QEI_INC_RST = 32'h0001_0000;
	localparam logic [31:0] QEI_WARN_RST = 32'hFFFF_FFFF;
	localparam logic [QEI_ST_W-1:0] QEI_MASK_RST = 7'h00;
	// decimal fraction base, one unit is 1/10000
	localparam logic [16:0] QEI_DEC_BASE = 17'h02710;
endpackage

// ===== hw/qei_decode.sv
// input synchroniser and quadrature step decoder
`timescale 1ns/1ns
module qei_decode (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [2:0] raw_abn,
	input wire logic [2:0] pol_abn,
	output logic step_q,
	output logic dir_q,
	output logic a_evt_q,
	output logic b_evt_q,
	output logic n_evt_q,
	output logic qerr_q
);
	logic [2:0] s1_q;
	logic [2:0] s2_q;
	logic [2:0] lvl_q;
	logic [2:0] lvl_d;
	logic step_d, dir_d, a_evt_d, b_evt_d, n_evt_d, qerr_d;

	// two-stage synchroniser, one per input
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1_q[gi] <= 1'b0;
					s2_q[gi] <= 1'b0;
				end else begin
					s1_q[gi] <= raw_abn[gi];
					s2_q[gi] <= s1_q[gi];
				end
			end
		end
	endgenerate

	// polarity, gray-code step and direction decode
	always_comb begin
		lvl_d = s2_q ^ pol_abn;
		a_evt_d = lvl_d[0] ^ lvl_q[0];
		b_evt_d = lvl_d[1] ^ lvl_q[1];
		n_evt_d = lvl_d[2] & ~lvl_q[2];
		step_d = a_evt_d ^ b_evt_d;
		qerr_d = a_evt_d & b_evt_d;
		// a moving alone: forward when a differs from b; b alone: forward when equal
		dir_d = a_evt_d ? (lvl_d[0] ^ lvl_d[1]) : ~(lvl_d[0] ^ lvl_d[1]);
	end

	// registered decode results
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lvl_q <= 3'h0;
			step_q <= 1'b0;
			dir_q <= 1'b0;
			a_evt_q <= 1'b0;
			b_evt_q <= 1'b0;
			n_evt_q <= 1'b0;
			qerr_q <= 1'b0;
		end else begin
			lvl_q <= lvl_d;
			step_q <= step_d;
			dir_q <= dir_d;
			a_evt_q <= a_evt_d;
			b_evt_q <= b_evt_d;
			n_evt_q <= n_evt_d;
			qerr_q <= qerr_d;
		end
	end
endmodule // qei_decode

// ===== hw/qei_top.sv
// quadrature encoder interface with apb registers
//
// Contract
// - add or subtract increment per decoded step
// - increment is unsigned 16.16 fixed point
// - decimal mode: low half counts 0..9999
// - fraction weight 1/65536 binary, 1/10000 decimal
// - index event may clear position counter
// - option: clear only on first index
// - position counter readable by software
// - selectable polarity for a, b, n
// - a, b, n events recorded in status
// - index event captures encoder position
// - switch event captures position
// - interrupt when deviation exceeds warning distance
// - error is encoder minus sequencer position
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ns
module qei_top
	import qei_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic enc_a,
	input wire logic enc_b,
	input wire logic enc_n,
	input wire logic ref_switch_evt,
	input wire logic [31:0] seq_pos,
	input wire logic pid_en,
	output logic [31:0] enc_pos,
	output logic [31:0] pos_err,
	output logic irq
);
	// decoder outputs
	logic step;
	logic dir;
	logic a_evt;
	logic b_evt;
	logic n_evt;
	logic qerr;

	// configuration, position and capture state
	logic [QEI_CTRL_W-1:0] ctrl_q;
	logic [QEI_CTRL_W-1:0] ctrl_d;
	logic [31:0] inc_q;
	logic [31:0] inc_d;
	logic [31:0] pos_q;
	logic [31:0] pos_d;
	logic [15:0] frac_q;
	logic [15:0] frac_d;
	logic [31:0] idx_cap_q;
	logic [31:0] idx_cap_d;
	logic [31:0] sw_cap_q;
	logic [31:0] sw_cap_d;
	logic [31:0] warn_q;
	logic [31:0] warn_d;
	logic [QEI_ST_W-1:0] mask_q;
	logic [QEI_ST_W-1:0] mask_d;
	logic done_q;
	logic done_d;

	// deviation, status and interrupt state
	logic [31:0] err_q;
	logic [31:0] err_d;
	logic [QEI_ST_W-1:0] stat_q;
	logic [QEI_ST_W-1:0] stat_d;
	logic irq_q;
	logic irq_d;

	// apb answer state
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic pready_q;
	logic pready_d;
	logic pslverr_q;
	logic pslverr_d;

	// helper nets
	logic wr;
	logic hit;
	logic [31:0] rdata;
	logic [16:0] fsum;
	logic [16:0] fdif;
	logic carry;
	logic borrow;
	logic [15:0] fnext;
	logic [31:0] pnext;
	logic [31:0] abs_err;
	logic [QEI_ST_W-1:0] ev;
	logic clr_ok;

	// input synchroniser and step decoder
	qei_decode u_dec (
		.pclk(pclk),
		.presetn(presetn),
		.raw_abn({enc_n, enc_b, enc_a}),
		.pol_abn({ctrl_q[QEI_CTRL_POL_N], ctrl_q[QEI_CTRL_POL_B], ctrl_q[QEI_CTRL_POL_A]}),
		.step_q(step),
		.dir_q(dir),
		.a_evt_q(a_evt),
		.b_evt_q(b_evt),
		.n_evt_q(n_evt),
		.qerr_q(qerr)
	);

	// apb read mux and address decode
	always_comb begin
		hit = 1'b1;
		rdata = 32'h0000_0000;
		unique case (paddr)
			QEI_OFS_CTRL: rdata = {{(32-QEI_CTRL_W){1'b0}}, ctrl_q};
			QEI_OFS_INC: rdata = inc_q;
			QEI_OFS_POS: rdata = pos_q;
			QEI_OFS_FRAC: rdata = {16'h0000, frac_q};
			QEI_OFS_IDX_CAP: rdata = idx_cap_q;
			QEI_OFS_SW_CAP: rdata = sw_cap_q;
			QEI_OFS_WARN: rdata = warn_q;
			QEI_OFS_STAT: rdata = {{(32-QEI_ST_W){1'b0}}, stat_q};
			QEI_OFS_MASK: rdata = {{(32-QEI_ST_W){1'b0}}, mask_q};
			default: hit = 1'b0;
		endcase
		wr = psel & penable & pready_q & pwrite;
	end

	// apb handshake: setup cycle prepares the answer, access ends in one cycle
	always_comb begin
		pready_d = psel & ~penable;
		prdata_d = prdata_q;
		pslverr_d = 1'b0;
		if (psel & ~penable) begin
			prdata_d = pwrite ? 32'h0000_0000 : rdata;
			pslverr_d = ~hit;
		end
	end

	// fractional accumulator, binary or decimal weight
	always_comb begin
		fsum = {1'b0, frac_q} + {1'b0, inc_q[15:0]};
		fdif = {1'b0, frac_q} - {1'b0, inc_q[15:0]};
		borrow = fdif[16];
		if (ctrl_q[QEI_CTRL_DEC]) begin
			carry = (fsum >= QEI_DEC_BASE);
			if (dir) begin
				fnext = carry ? 16'(fsum - QEI_DEC_BASE) : fsum[15:0];
			end else begin
				fnext = borrow ? 16'(fdif + QEI_DEC_BASE) : fdif[15:0];
			end
		end else begin
			carry = fsum[16];
			fnext = dir ? fsum[15:0] : fdif[15:0];
		end
		if (dir) begin
			pnext = pos_q + {16'h0000, inc_q[31:16]} + {31'h0, carry};
		end else begin
			pnext = pos_q - {16'h0000, inc_q[31:16]} - {31'h0, borrow};
		end
	end

	// position counter, index clearing and captures
	always_comb begin
		ctrl_d = ctrl_q;
		inc_d = inc_q;
		warn_d = warn_q;
		mask_d = mask_q;
		pos_d = pos_q;
		frac_d = frac_q;
		idx_cap_d = idx_cap_q;
		sw_cap_d = sw_cap_q;
		done_d = done_q;
		clr_ok = ctrl_q[QEI_CTRL_CLR_N] & ~(ctrl_q[QEI_CTRL_CLR_ONCE] & done_q);
		if (step) begin
			pos_d = pnext;
			frac_d = fnext;
		end
		// index: capture the pre-step position, then optional clear
		if (n_evt) begin
			idx_cap_d = pos_q;
			if (clr_ok) begin
				pos_d = 32'h0000_0000;
				frac_d = 16'h0000;
				done_d = 1'b1;
			end
		end
		if (ref_switch_evt) begin
			sw_cap_d = seq_pos;
		end
		// software writes override hardware updates, except that a clearing index still sets done
		if (wr) begin
			unique case (paddr)
				QEI_OFS_CTRL: begin
					ctrl_d = pwdata[QEI_CTRL_W-1:0];
					done_d = n_evt & clr_ok; // rearm, a clearing index now wins
				end
				QEI_OFS_INC: inc_d = pwdata;
				QEI_OFS_POS: begin
					pos_d = pwdata;
					frac_d = 16'h0000;
				end
				QEI_OFS_WARN: warn_d = pwdata;
				QEI_OFS_MASK: mask_d = pwdata[QEI_ST_W-1:0];
				default: ;
			endcase
		end
	end

	// deviation between encoder and sequencer position
	always_comb begin
		err_d = pos_q - seq_pos;
	end

	// sticky status and interrupt
	always_comb begin
		abs_err = err_q[31] ? (32'h0000_0000 - err_q) : err_q;
		ev = '0;
		ev[QEI_ST_A] = a_evt;
		ev[QEI_ST_B] = b_evt;
		ev[QEI_ST_N] = n_evt;
		ev[QEI_ST_WARN] = pid_en & (abs_err > warn_q);
		ev[QEI_ST_SW] = ref_switch_evt;
		ev[QEI_ST_QERR] = qerr;
		ev[QEI_ST_DONE] = n_evt & clr_ok;
		stat_d = stat_q;
		if (wr && paddr == QEI_OFS_STAT) begin
			stat_d = stat_q & ~pwdata[QEI_ST_W-1:0];
		end
		stat_d = stat_d | ev; // set wins over clear
		irq_d = |(stat_d & mask_d);
	end

	// apb answer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// configuration, position and capture registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= QEI_CTRL_RST;
			inc_q <= QEI_INC_RST;
			warn_q <= QEI_WARN_RST;
			mask_q <= QEI_MASK_RST;
			pos_q <= 32'h0000_0000;
			frac_q <= 16'h0000;
			idx_cap_q <= 32'h0000_0000;
			sw_cap_q <= 32'h0000_0000;
			done_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			inc_q <= inc_d;
			warn_q <= warn_d;
			mask_q <= mask_d;
			pos_q <= pos_d;
			frac_q <= frac_d;
			idx_cap_q <= idx_cap_d;
			sw_cap_q <= sw_cap_d;
			done_q <= done_d;
		end
	end

	// deviation register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_q <= 32'h0000_0000;
		end else begin
			err_q <= err_d;
		end
	end

	// status and interrupt registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q <= '0;
			irq_q <= 1'b0;
		end else begin
			stat_q <= stat_d;
			irq_q <= irq_d;
		end
	end

	// outputs straight from flip-flops
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign enc_pos = pos_q;
	assign pos_err = err_q;
	assign irq = irq_q;
endmodule // qei_top

// ===== tb/qei_props.sv
// port assertions for the encoder interface
`timescale 1ns/1ns
module qei_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic enc_a,
	input wire logic enc_b,
	input wire logic enc_n,
	input wire logic [31:0] seq_pos,
	input wire logic [31:0] enc_pos,
	input wire logic [31:0] pos_err,
	input wire logic irq
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// outputs clear on leaving reset
	property p_rst;
		$rose(presetn) |-> !pready && !irq && enc_pos == 32'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("not clear after reset");
	// apb answer and refusal
	property p_rdy;
		psel && !penable |=> pready && penable;
	endproperty
	a_rdy: assert property (p_rdy) else $error("no ready");
	property p_ack;
		pready |-> psel && penable && $past(psel && !penable);
	endproperty
	a_ack: assert property (p_ack) else $error("stray ready");
	property p_map;
		psel && !penable && paddr > 8'h20 |=> pslverr;
	endproperty
	a_map: assert property (p_map) else $error("no error");
	property p_ok;
		psel && !penable && paddr[1:0] == 2'h0 && paddr <= 8'h20 |=> !pslverr;
	endproperty
	a_ok: assert property (p_ok) else $error("stray error");
	// error is position minus sequencer
	property p_err;
		!$rose(presetn) |-> pos_err == $past(enc_pos) - $past(seq_pos);
	endproperty
	a_err: assert property (p_err) else $error("bad error");
	// quiet pins leave position alone
	property p_hold;
		(!psel && $stable({enc_a, enc_b, enc_n}))[*5] |=> $stable(enc_pos);
	endproperty
	a_hold: assert property (p_hold) else $error("drift");
	// irq only drops after an apb access phase
	property p_irq;
		$fell(irq) |-> $past(psel && penable) || $past(psel && penable, 2);
	endproperty
	a_irq: assert property (p_irq) else $error("irq dropped");
endmodule // qei_props

// ===== tb/qei_enc_model.sv
// behavioural quadrature encoder
`timescale 1ns/1ns
module qei_enc_model (
	input wire logic pclk,
	input wire logic [1:0] cmd,
	input wire logic inv,
	output logic a,
	output logic b,
	output logic n
);
	logic [1:0] s_q = 2'h0;
	logic n_q = 1'b0;
	// one gray step per command, index on 3
	always @(posedge pclk) begin
		if (cmd == 2'h1) begin
			s_q <= s_q + 2'h1;
		end else if (cmd == 2'h2) begin
			s_q <= s_q - 2'h1;
		end
		n_q <= cmd == 2'h3;
	end
	// forward order 00 10 11 01
	assign a = s_q[0] ^ s_q[1] ^ inv;
	assign b = s_q[1] ^ inv;
	assign n = n_q ^ inv;
endmodule // qei_enc_model

// ===== tb/qei_top_tb.sv
// bench for the encoder interface
`timescale 1ns/1ns
module qei_top_tb;
	import qei_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ref_sw = 0, pid_en = 0;
	logic inv = 0, pready, pslverr, irq, ea, eb, en, se;
	logic [1:0] cmd = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, seq_pos = 0, prdata, enc_pos, pos_err, rd;
	int mismatches = 0, n_checks = 0, cyc = 0;
	always #5 pclk = ~pclk;
	qei_enc_model enc_u (.pclk(pclk), .cmd(cmd), .inv(inv), .a(ea), .b(eb), .n(en));
	qei_top dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .enc_a(ea), .enc_b(eb), .enc_n(en),
		.ref_switch_evt(ref_sw), .seq_pos(seq_pos), .pid_en(pid_en),
		.enc_pos(enc_pos), .pos_err(pos_err), .irq(irq));
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH %0t got %h want %h", $time, s, e);
		end
	endtask
	task wrap_up;
		$display("mismatches %0d checks %0d", mismatches, n_checks);
		if (mismatches == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// one apb transfer, waits for ready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task rc(input logic [7:0] a, input logic [31:0] e);
		apb(0, a, 32'h0);
		chk(rd, e);
	endtask
	// k encoder commands, then settle
	task step(input logic [1:0] c, input int k);
		repeat (k) begin
			cmd <= c;
			@(posedge pclk);
			cmd <= 0;
			repeat (3) @(posedge pclk);
		end
		repeat (6) @(posedge pclk);
	endtask
	task t_regs;
		rc(QEI_OFS_INC, QEI_INC_RST);
		rc(QEI_OFS_WARN, QEI_WARN_RST);
		rc(8'h40, 32'h0);
		chk(se, 32'h1);
	endtask
	task t_frac;
		apb(1, QEI_OFS_INC, 32'h0001_8000);
		step(1, 4);
		rc(QEI_OFS_POS, 32'h6);
		step(2, 1);
		chk(enc_pos, 32'h4);
		rc(QEI_OFS_FRAC, 32'h8000);
		apb(1, QEI_OFS_CTRL, 32'h1);
		apb(1, QEI_OFS_POS, 32'h0);
		apb(1, QEI_OFS_INC, 32'h0199_1770);
		step(1, 5);
		rc(QEI_OFS_POS, 32'h800);
		rc(QEI_OFS_FRAC, 32'h0);
		step(2, 1);
		rc(QEI_OFS_POS, 32'h666);
		rc(QEI_OFS_FRAC, 32'hFA0);
	endtask
	task t_idx;
		apb(1, QEI_OFS_CTRL, 32'h30);
		apb(1, QEI_OFS_INC, 32'h0001_0000);
		apb(1, QEI_OFS_STAT, 32'h7F);
		step(1, 3);
		step(3, 1);
		rc(QEI_OFS_IDX_CAP, 32'h669);
		chk(enc_pos, 32'h0);
		rc(QEI_OFS_STAT, 32'h47);
		step(1, 2);
		step(3, 1);
		chk(enc_pos, 32'h2);
		rc(QEI_OFS_IDX_CAP, 32'h2);
	endtask
	task t_pol;
		inv <= 1;
		apb(1, QEI_OFS_CTRL, 32'h0E);
		step(0, 1);
		apb(1, QEI_OFS_POS, 32'h10);
		apb(1, QEI_OFS_STAT, 32'h7F);
		step(2, 1);
		chk(enc_pos, 32'hF);
		rc(QEI_OFS_STAT, 32'h2);
	endtask
	task t_irq;
		seq_pos <= 32'h1234;
		ref_sw <= 1;
		@(posedge pclk);
		ref_sw <= 0;
		apb(1, QEI_OFS_MASK, 32'h18);
		repeat (2) @(posedge pclk);
		chk(irq, 32'h1);
		rc(QEI_OFS_SW_CAP, 32'h1234);
		apb(1, QEI_OFS_STAT, 32'h10);
		repeat (2) @(posedge pclk);
		chk(irq, 32'h0);
		pid_en <= 1;
		apb(1, QEI_OFS_WARN, 32'h5);
		seq_pos <= 32'hFFFF_FFF0;
		repeat (3) @(posedge pclk);
		chk(pos_err, 32'h1F);
		chk(irq, 32'h1);
		seq_pos <= 32'hA;
		repeat (3) @(posedge pclk);
		apb(1, QEI_OFS_STAT, 32'h08);
		repeat (2) @(posedge pclk);
		chk(irq, 32'h0);
	endtask
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		t_regs;
		t_frac;
		t_idx;
		t_pol;
		t_irq;
		wrap_up;
	end
	// hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			wrap_up;
		end
	end
endmodule // qei_top_tb
bind qei_top qei_props props_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .enc_a(enc_a),
	.enc_b(enc_b), .enc_n(enc_n), .seq_pos(seq_pos), .enc_pos(enc_pos),
	.pos_err(pos_err), .irq(irq));
